// File: verilog/tpf_pkg.sv
package tpf_pkg;

  // Queue geometry
  localparam int          TPF_DEPTH    = 64;
  localparam int          TPF_AW       = 6;
  localparam int          TPF_PW       = 7;
  localparam int          TPF_DW       = 36;
  localparam int          TPF_HW       = 18;
  localparam int          TPF_BW       = 9;
  localparam logic [6:0]  TPF_FULL_CNT = 7'h40;
  localparam logic [6:0]  TPF_PTR_RST  = 7'h00;

  // Almost-flag offsets, indexed by {offset_sel_hi, offset_sel_lo}
  localparam logic [6:0]  TPF_OFS_0    = 7'h04;
  localparam logic [6:0]  TPF_OFS_1    = 7'h08;
  localparam logic [6:0]  TPF_OFS_2    = 7'h0c;
  localparam logic [6:0]  TPF_OFS_3    = 7'h10;

  // Narrow-port piece counts (last phase index)
  localparam logic [1:0]  TPF_LAST_WORD = 2'h1;
  localparam logic [1:0]  TPF_LAST_BYTE = 2'h3;

  // APB register byte addresses
  localparam logic [11:0] TPF_REG_CTRL = 12'h000;
  localparam logic [11:0] TPF_REG_STAT = 12'h004;
  localparam logic [11:0] TPF_REG_LVL  = 12'h008;

  // Status and level field positions
  localparam int          TPF_STAT_OFS_LSB = 16;
  localparam int          TPF_LVL_CA_LSB   = 16;

  // Reset values
  localparam logic [6:0]  TPF_CTRL_RST  = 7'h00;
  localparam logic [1:0]  TPF_READY_RST = 2'h0;
  localparam logic        TPF_IDLE_RST  = 1'b1;

  typedef struct packed {
    logic byte_c;
    logic byte_b;
    logic swap_c;
    logic swap_b;
    logic pgen_b;
    logic pgen_a;
    logic odd;
  } tpf_ctrl_t;

  typedef struct packed {
    logic [6:0] wptr;
    logic [6:0] rptr;
  } tpf_ptrs_t;

endpackage

// File: verilog/tpf_fifo_top.sv
// Operation
// - Two 64x36 queues, A-to-B and C-to-A
// - Port A 36-bit two-way, B out, C in
// - Ports B and C: word or byte size
// - Byte order swap on B and C
// - Passive parity check on A and C writes
// - Selectable parity generation on A, B reads
// - Transfers only on enabled rising clock edge
// - One shared clock pclk for all ports, simultaneous read and write
// - First word stored; explicit read fetches it
// - Reset zeroes all read and write pointers
// - Offset selects sampled at reset choose X
// - Empty and full flags per queue
// - Full flags two-stage synced to writer
// - Empty flags two-stage synced to reader
// - Port A almost-empty low at count <= X
// - Port B almost-empty low at count <= X
// - Port A almost-full low at free <= X
// - Port C almost-full low at free <= X
// - Idle when inactive, wake on port A transfer, B read, C write or psel
// - Port A moves only when selected and gated
// - Port A empty rises second edge after data
// - Port A full rises second edge after reset
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
module tpf_fifo_top
  import tpf_pkg::*;
#(
  parameter logic [6:0] OFS_SEL0 = TPF_OFS_0,
  parameter logic [6:0] OFS_SEL1 = TPF_OFS_1,
  parameter logic [6:0] OFS_SEL2 = TPF_OFS_2,
  parameter logic [6:0] OFS_SEL3 = TPF_OFS_3
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Offset selects
  input  wire logic        offset_sel_lo,
  input  wire logic        offset_sel_hi,
  // Port A
  input  wire logic        porta_select_n,
  input  wire logic        porta_xfer_gate,
  input  wire logic        porta_write,
  input  wire logic [35:0] porta_bus_in,
  output logic [35:0]      porta_bus_out,
  output logic             porta_bus_oe_n,
  output logic             porta_empty_flag_n,
  output logic             porta_full_flag_n,
  output logic             porta_almost_empty_n,
  output logic             porta_almost_full_n,
  output logic             porta_parity_err_n,
  // Port B
  input  wire logic        portb_read,
  output logic [17:0]      portb_bus,
  output logic             portb_empty_flag_n,
  output logic             portb_almost_empty_n,
  // Port C
  input  wire logic        portc_write,
  input  wire logic [17:0] portc_bus,
  output logic             portc_full_flag_n,
  output logic             portc_almost_full_n,
  output logic             portc_parity_err_n,
  // Power state
  output logic             low_power_idle
);

  function automatic logic par_ok(logic [8:0] b, logic odd);
    par_ok = ((^b) == odd);
  endfunction

  function automatic logic [8:0] gen_byte(logic [8:0] b, logic en, logic odd);
    gen_byte = en ? {(^b[7:0]) ^ odd, b[7:0]} : b;
  endfunction

  function automatic logic word_par_ok(logic [35:0] w, logic odd);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ok = ok & par_ok(w[i*TPF_BW +: TPF_BW], odd);
    end
    word_par_ok = ok;
  endfunction

  function automatic logic [35:0] gen_word(logic [35:0] w, logic en, logic odd);
    logic [35:0] r;
    r = w;
    for (int i = 0; i < 4; i++)
    begin
      r[i*TPF_BW +: TPF_BW] = gen_byte(w[i*TPF_BW +: TPF_BW], en, odd);
    end
    gen_word = r;
  endfunction

  function automatic logic [6:0] diff7(logic [6:0] a, logic [6:0] b);
    diff7 = a - b;
  endfunction

  function automatic logic [6:0] ofs_lookup(logic [1:0] s);
    case (s)
      2'h0:    ofs_lookup = OFS_SEL0;
      2'h1:    ofs_lookup = OFS_SEL1;
      2'h2:    ofs_lookup = OFS_SEL2;
      default: ofs_lookup = OFS_SEL3;
    endcase
  endfunction

  tpf_ctrl_t   ctrl_ff;
  tpf_ptrs_t   ab_ff;
  tpf_ptrs_t   ca_ff;
  logic [35:0] mem_ab [TPF_DEPTH];
  logic [35:0] mem_ca [TPF_DEPTH];
  logic [6:0]  wab_s1_ff;
  logic [6:0]  wab_s2_ff;
  logic [6:0]  rab_s1_ff;
  logic [6:0]  rab_s2_ff;
  logic [6:0]  wca_s1_ff;
  logic [6:0]  wca_s2_ff;
  logic [6:0]  rca_s1_ff;
  logic [6:0]  rca_s2_ff;
  logic [1:0]  ready_ff;
  logic [1:0]  ofs_s1_ff;
  logic [1:0]  ofs_s2_ff;
  logic        ofs_cap_done_ff;
  logic [6:0]  ofs_x_ff;
  logic [35:0] porta_out_ff;
  logic [17:0] portb_out_ff;
  logic [1:0]  b_phase_ff;
  logic [1:0]  c_phase_ff;
  logic [35:0] c_asm_ff;
  logic [35:0] nxt_c_asm;
  logic        pa_perr_ff;
  logic        pc_perr_ff;
  logic        idle_ff;
  logic [31:0] prdata_ff;
  logic [6:0]  cnt_ab_wr;
  logic [6:0]  cnt_ab_rd;
  logic [6:0]  cnt_ca_wr;
  logic [6:0]  cnt_ca_rd;
  logic        ab_full_n;
  logic        ab_empty_n;
  logic        ca_full_n;
  logic        ca_empty_n;
  logic        a_xfer;
  logic        a_wr;
  logic        a_rd;
  logic        b_rd;
  logic        b_last;
  logic [1:0]  b_lastph;
  logic [1:0]  b_idx;
  logic [35:0] b_word;
  logic        c_wr;
  logic        c_last;
  logic [1:0]  c_lastph;
  logic [1:0]  c_idx;
  logic        c_par;
  logic        apb_mapped;

  // Counts seen from each side through the synced far pointer
  assign cnt_ab_wr  = diff7(ab_ff.wptr, rab_s2_ff);
  assign cnt_ab_rd  = diff7(wab_s2_ff, ab_ff.rptr);
  assign cnt_ca_wr  = diff7(ca_ff.wptr, rca_s2_ff);
  assign cnt_ca_rd  = diff7(wca_s2_ff, ca_ff.rptr);
  assign ab_full_n  = ready_ff[1] && (cnt_ab_wr != TPF_FULL_CNT);
  assign ca_full_n  = ready_ff[1] && (cnt_ca_wr != TPF_FULL_CNT);
  assign ab_empty_n = (cnt_ab_rd != TPF_PTR_RST);
  assign ca_empty_n = (cnt_ca_rd != TPF_PTR_RST);

  assign porta_full_flag_n    = ab_full_n;
  assign portc_full_flag_n    = ca_full_n;
  assign porta_empty_flag_n   = ca_empty_n;
  assign portb_empty_flag_n   = ab_empty_n;
  assign porta_almost_empty_n = (cnt_ca_rd > ofs_x_ff);
  assign portb_almost_empty_n = (cnt_ab_rd > ofs_x_ff);
  assign porta_almost_full_n  = (diff7(TPF_FULL_CNT, cnt_ab_wr) > ofs_x_ff);
  assign portc_almost_full_n  = (diff7(TPF_FULL_CNT, cnt_ca_wr) > ofs_x_ff);

  // Port A qualification
  assign a_xfer = !porta_select_n && porta_xfer_gate;
  assign a_wr   = a_xfer && porta_write && ab_full_n;
  assign a_rd   = a_xfer && !porta_write && ca_empty_n;

  // Port B piece select
  assign b_lastph = ctrl_ff.byte_b ? TPF_LAST_BYTE : TPF_LAST_WORD;
  assign b_idx    = ctrl_ff.swap_b ? b_lastph - b_phase_ff : b_phase_ff;
  assign b_last   = (b_phase_ff == b_lastph);
  assign b_rd     = portb_read && ab_empty_n;
  assign b_word   = mem_ab[ab_ff.rptr[TPF_AW-1:0]];

  // Port C piece placement
  assign c_lastph = ctrl_ff.byte_c ? TPF_LAST_BYTE : TPF_LAST_WORD;
  assign c_idx    = ctrl_ff.swap_c ? c_lastph - c_phase_ff : c_phase_ff;
  assign c_last   = (c_phase_ff == c_lastph);
  assign c_wr     = portc_write && ca_full_n;

  always_comb
  begin
    nxt_c_asm = c_asm_ff;
    if (ctrl_ff.byte_c)
    begin
      nxt_c_asm[c_idx*TPF_BW +: TPF_BW] = portc_bus[8:0];
      c_par = par_ok(portc_bus[8:0], ctrl_ff.odd);
    end
    else
    begin
      nxt_c_asm[c_idx[0]*TPF_HW +: TPF_HW] = portc_bus;
      c_par = par_ok(portc_bus[8:0], ctrl_ff.odd) && par_ok(portc_bus[17:9], ctrl_ff.odd);
    end
  end

  // Reset release sequencing for full flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ready_ff <= TPF_READY_RST;
    else
      ready_ff <= {ready_ff[0], 1'b1};
  end

  // Offset selects: synced, latched once after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ofs_s1_ff       <= 2'h0;
      ofs_s2_ff       <= 2'h0;
      ofs_cap_done_ff <= 1'b0;
      ofs_x_ff        <= TPF_OFS_0;
    end
    else
    begin
      ofs_s1_ff <= {offset_sel_hi, offset_sel_lo};
      ofs_s2_ff <= ofs_s1_ff;
      if (ready_ff[1] && !ofs_cap_done_ff)
      begin
        ofs_cap_done_ff <= 1'b1;
        ofs_x_ff        <= ofs_lookup(ofs_s2_ff);
      end
    end
  end

  // Queue A-to-B pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ab_ff <= '{wptr: TPF_PTR_RST, rptr: TPF_PTR_RST};
    else
    begin
      if (a_wr)
        ab_ff.wptr <= ab_ff.wptr + 7'h01;
      if (b_rd && b_last)
        ab_ff.rptr <= ab_ff.rptr + 7'h01;
    end
  end

  // Queue C-to-A pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ca_ff <= '{wptr: TPF_PTR_RST, rptr: TPF_PTR_RST};
    else
    begin
      if (c_wr && c_last)
        ca_ff.wptr <= ca_ff.wptr + 7'h01;
      if (a_rd)
        ca_ff.rptr <= ca_ff.rptr + 7'h01;
    end
  end

  // Pointer crossings, two stages each way
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wab_s1_ff <= TPF_PTR_RST;
      wab_s2_ff <= TPF_PTR_RST;
      rab_s1_ff <= TPF_PTR_RST;
      rab_s2_ff <= TPF_PTR_RST;
      wca_s1_ff <= TPF_PTR_RST;
      wca_s2_ff <= TPF_PTR_RST;
      rca_s1_ff <= TPF_PTR_RST;
      rca_s2_ff <= TPF_PTR_RST;
    end
    else
    begin
      wab_s1_ff <= ab_ff.wptr;
      wab_s2_ff <= wab_s1_ff;
      rab_s1_ff <= ab_ff.rptr;
      rab_s2_ff <= rab_s1_ff;
      wca_s1_ff <= ca_ff.wptr;
      wca_s2_ff <= wca_s1_ff;
      rca_s1_ff <= ca_ff.rptr;
      rca_s2_ff <= rca_s1_ff;
    end
  end

  // Storage arrays
  always_ff @(posedge pclk)
  begin
    if (a_wr)
      mem_ab[ab_ff.wptr[TPF_AW-1:0]] <= porta_bus_in;
    if (c_wr && c_last)
      mem_ca[ca_ff.wptr[TPF_AW-1:0]] <= nxt_c_asm;
  end

  // Port A output register and parity check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porta_out_ff <= 36'h0;
      pa_perr_ff   <= 1'b0;
    end
    else
    begin
      if (a_rd)
        porta_out_ff <= gen_word(mem_ca[ca_ff.rptr[TPF_AW-1:0]], ctrl_ff.pgen_a, ctrl_ff.odd);
      if (a_xfer && porta_write)
        pa_perr_ff <= !word_par_ok(porta_bus_in, ctrl_ff.odd);
    end
  end

  assign porta_bus_out      = porta_out_ff;
  assign porta_bus_oe_n     = !(!porta_select_n && !porta_write);
  assign porta_parity_err_n = !pa_perr_ff;

  // Port B narrow reader
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      portb_out_ff <= 18'h0;
      b_phase_ff   <= 2'h0;
    end
    else if (b_rd)
    begin
      b_phase_ff <= b_last ? 2'h0 : b_phase_ff + 2'h1;
      if (ctrl_ff.byte_b)
        portb_out_ff <= {9'h0, gen_byte(b_word[b_idx*TPF_BW +: TPF_BW], ctrl_ff.pgen_b, ctrl_ff.odd)};
      else
        portb_out_ff <= {gen_byte(b_word[b_idx[0]*TPF_HW+TPF_BW +: TPF_BW], ctrl_ff.pgen_b, ctrl_ff.odd),
                         gen_byte(b_word[b_idx[0]*TPF_HW +: TPF_BW], ctrl_ff.pgen_b, ctrl_ff.odd)};
    end
  end

  assign portb_bus = portb_out_ff;

  // Port C narrow writer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c_asm_ff   <= 36'h0;
      c_phase_ff <= 2'h0;
      pc_perr_ff <= 1'b0;
    end
    else if (c_wr)
    begin
      c_asm_ff   <= nxt_c_asm;
      c_phase_ff <= c_last ? 2'h0 : c_phase_ff + 2'h1;
      pc_perr_ff <= !c_par;
    end
  end

  assign portc_parity_err_n = !pc_perr_ff;

  // Idle detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_ff <= TPF_IDLE_RST;
    else
      idle_ff <= !(a_xfer || portb_read || portc_write || psel);
  end

  assign low_power_idle = idle_ff && !(a_xfer || portb_read || portc_write || psel);

  // APB slave
  assign apb_mapped = (paddr == TPF_REG_CTRL) || (paddr == TPF_REG_STAT) || (paddr == TPF_REG_LVL);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !apb_mapped;
  assign prdata     = prdata_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= TPF_CTRL_RST;
    else if (psel && penable && pwrite && (paddr == TPF_REG_CTRL))
      ctrl_ff <= pwdata[6:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0;
    else if (psel && !penable)
    begin
      case (paddr)
        TPF_REG_CTRL: prdata_ff <= {25'h0, ctrl_ff};
        TPF_REG_STAT: prdata_ff <= {9'h0, ofs_x_ff, 5'h0, low_power_idle, portc_parity_err_n, porta_parity_err_n,
                                    portc_almost_full_n, portc_full_flag_n, portb_almost_empty_n,
                                    portb_empty_flag_n, porta_almost_full_n, porta_almost_empty_n,
                                    porta_full_flag_n, porta_empty_flag_n};
        TPF_REG_LVL:  prdata_ff <= {9'h0, cnt_ca_rd, 9'h0, cnt_ab_rd};
        default:      prdata_ff <= 32'h0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_load_empty_ca;
    c_wr && c_last && (ca_ff.wptr == ca_ff.rptr) && (wca_s2_ff == ca_ff.wptr);
  endsequence

  sequence s_empty_rise;
    !porta_empty_flag_n ##1 !porta_empty_flag_n ##1 porta_empty_flag_n;
  endsequence

  chk_a_empty_rise: assert property (s_load_empty_ca |=> s_empty_rise)
    else $error("port A empty flag did not rise on second edge");
  chk_full_at_reset: assert property ((ready_ff != 2'h3) |-> !porta_full_flag_n && !portc_full_flag_n)
    else $error("full flag high before second edge after reset");
  chk_ptrs_reset: assert property ((ready_ff != 2'h3) |-> (ab_ff.wptr == 7'h0) && (ca_ff.rptr == 7'h0))
    else $error("pointers moved before reset release settled");
  chk_ab_no_over: assert property (diff7(ab_ff.wptr, ab_ff.rptr) <= TPF_FULL_CNT)
    else $error("A-to-B queue holds more than 64 words");
  chk_ae_porta: assert property ((diff7(ca_ff.wptr, ca_ff.rptr) <= ofs_x_ff) |-> !porta_almost_empty_n)
    else $error("port A almost-empty high at or below offset");
  chk_ae_portb: assert property ((diff7(ab_ff.wptr, ab_ff.rptr) <= ofs_x_ff) |-> !portb_almost_empty_n)
    else $error("port B almost-empty high at or below offset");
  chk_af_porta: assert property ((diff7(TPF_FULL_CNT, diff7(ab_ff.wptr, ab_ff.rptr)) <= ofs_x_ff)
                                 |-> !porta_almost_full_n)
    else $error("port A almost-full high at or below offset");
  chk_af_portc: assert property ((diff7(TPF_FULL_CNT, diff7(ca_ff.wptr, ca_ff.rptr)) <= ofs_x_ff)
                                 |-> !portc_almost_full_n)
    else $error("port C almost-full high at or below offset");
  chk_a_gate_hold: assert property (!a_xfer |=> $stable(ab_ff.wptr) && $stable(ca_ff.rptr))
    else $error("port A moved data while not selected");
  chk_b_piece_ptr: assert property (b_rd && !b_last |=> $stable(ab_ff.rptr))
    else $error("port B advanced pointer mid-word");
  chk_ofs_latch: assert property ($rose(ofs_cap_done_ff) |-> ofs_x_ff == ofs_lookup($past(ofs_s2_ff)))
    else $error("offset not taken from sampled selects");
  chk_a_par_gen: assert property (a_rd && ctrl_ff.pgen_a |=> word_par_ok(porta_bus_out, $past(ctrl_ff.odd)))
    else $error("port A generated parity wrong");
  chk_a_par_chk: assert property (a_xfer && porta_write && !word_par_ok(porta_bus_in, ctrl_ff.odd)
                                  |=> !porta_parity_err_n)
    else $error("port A parity error not flagged");
  chk_full_block: assert property (!porta_full_flag_n |=> $stable(ab_ff.wptr))
    else $error("write taken while port A full");

endmodule

// File: sim/tpf_far_model.sv
`timescale 1ns/10ps
module tpf_far_model
  import tpf_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Port C writer
  output logic             portc_write,
  output logic [17:0]      portc_bus,
  input  wire logic        portc_full_flag_n,
  // Port B reader
  output logic             portb_read,
  input  wire logic [17:0] portb_bus,
  input  wire logic        portb_empty_flag_n
);
  initial
  begin
    portc_write = 1'b0;
    portc_bus   = 18'h3ffff;
    portb_read  = 1'b0;
  end

  // Push one word as n pieces, holding each until the full flag allows
  task automatic send_c(input logic [35:0] w, input int n, input logic sw);
    int idx;
    for (int i = 0; i < n; i++)
    begin
      idx = sw ? n - 1 - i : i;
      portc_write <= 1'b1;
      portc_bus   <= (n == 2) ? w[18*idx +: 18] : {9'h000, w[9*idx +: 9]};
      do @(posedge pclk); while (portc_full_flag_n !== 1'b1);
    end
    portc_write <= 1'b0;
    portc_bus   <= ~portc_bus;
  endtask

  // Pull one word as n pieces; a piece is seen the edge after it is taken
  task automatic recv_b(output logic [35:0] w, input int n, input logic sw);
    int   iss;
    int   got;
    int   idx;
    logic tk;
    iss = 0;
    got = 0;
    tk  = 1'b0;
    w   = '0;
    portb_read <= 1'b1;
    while (got < n)
    begin
      @(posedge pclk);
      if (tk)
      begin
        idx = sw ? n - 1 - got : got;
        if (n == 2)
          w[18*idx +: 18] = portb_bus;
        else
          w[9*idx +: 9] = portb_bus[8:0];
        got++;
      end
      tk = (iss < n) && (portb_empty_flag_n === 1'b1);
      if (tk)
        iss++;
      if (iss == n)
        portb_read <= 1'b0;
    end
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
  begin \
    check_count++; \
    if ((gt) !== (ex)) \
    begin \
      errors++; \
      $display("Error %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module testbench
  import tpf_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        osel_lo, osel_hi, a_sel_n, a_gate, a_wr, a_oe_n;
  logic        a_ef_n, a_ff_n, a_ae_n, a_af_n, a_pe_n, er, idle;
  logic [35:0] a_in, a_out, w, r;
  logic        b_rd, b_ef_n, b_ae_n, c_wr, c_ff_n, c_af_n, c_pe_n;
  logic [17:0] b_bus, c_bus;
  logic [35:0] qq[$];
  int          errors, check_count, n;

  tpf_fifo_top tpf_fifo_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .offset_sel_lo(osel_lo),
    .offset_sel_hi(osel_hi), .porta_select_n(a_sel_n), .porta_xfer_gate(a_gate),
    .porta_write(a_wr), .porta_bus_in(a_in), .porta_bus_out(a_out),
    .porta_bus_oe_n(a_oe_n), .porta_empty_flag_n(a_ef_n), .porta_full_flag_n(a_ff_n),
    .porta_almost_empty_n(a_ae_n), .porta_almost_full_n(a_af_n),
    .porta_parity_err_n(a_pe_n), .portb_read(b_rd), .portb_bus(b_bus),
    .portb_empty_flag_n(b_ef_n), .portb_almost_empty_n(b_ae_n),
    .portc_write(c_wr), .portc_bus(c_bus), .portc_full_flag_n(c_ff_n),
    .portc_almost_full_n(c_af_n), .portc_parity_err_n(c_pe_n), .low_power_idle(idle));

  tpf_far_model tpf_far_model_inst (
    .pclk(pclk), .portc_write(c_wr), .portc_bus(c_bus), .portc_full_flag_n(c_ff_n),
    .portb_read(b_rd), .portb_bus(b_bus), .portb_empty_flag_n(b_ef_n));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [35:0] rnd();
    logic [63:0] t;
    t = {$urandom, $urandom};
    return t[35:0];
  endfunction

  function automatic logic [35:0] mkpar(logic [35:0] d, logic odd);
    for (int b = 0; b < 4; b++)
      d[9*b+8] = (^d[9*b +: 8]) ^ odd;
    return d;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic a_op(input logic sn, input logic g, input logic wr, input logic [35:0] d);
    @(posedge pclk);
    a_sel_n <= sn;
    a_gate  <= g;
    a_wr    <= wr;
    a_in    <= d;
    @(posedge pclk);
    a_sel_n <= 1'b1;
    a_gate  <= 1'b0;
    a_in    <= ~d;
  endtask

  task automatic a_rd();
    repeat (3) @(posedge pclk);
    a_op(1'b0, 1'b1, 1'b0, 36'h0);
    @(posedge pclk);
    r = a_out;
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    summarize();
  end

  initial
  begin
    void'($urandom(41));
    errors = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, osel_lo, osel_hi, a_gate, a_wr} = '0;
    {paddr, pwdata, a_in} = '0;
    a_sel_n = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("a_full_e1", 1'b0, a_ff_n)
    @(posedge pclk);
    `CHK("a_full_e2", 1'b1, a_ff_n)
    `CHK("b_empty", 1'b0, b_ef_n)
    `CHK("a_empty", 1'b0, a_ef_n)
    apb(1'b1, TPF_REG_CTRL, 32'h0000007f);
    apb(1'b0, TPF_REG_CTRL, 32'h0);
    `CHK("ctrl", 7'h7f, rd[6:0])
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped", 1'b1, er)
    `CHK("unmapped_rd", 32'h0, rd)
    apb(1'b0, TPF_REG_STAT, 32'h0);
    `CHK("x_sel0", TPF_OFS_0, rd[22:16])
    apb(1'b1, TPF_REG_CTRL, 32'h0);
    // Only the selected and gated write lands
    w = rnd();
    a_op(1'b1, 1'b1, 1'b1, ~w);
    a_op(1'b0, 1'b0, 1'b1, ~w);
    a_op(1'b0, 1'b1, 1'b1, w);
    @(posedge pclk);
    `CHK("b_ef_e1", 1'b0, b_ef_n)
    repeat (2) @(posedge pclk);
    `CHK("b_ef_e3", 1'b1, b_ef_n)
    tpf_far_model_inst.recv_b(r, 2, 1'b0);
    `CHK("gated", w, r)
    repeat (4) @(posedge pclk);
    `CHK("b_ef_end", 1'b0, b_ef_n)
    // Every size and swap combination on B and C
    for (int m = 0; m < 4; m++)
    begin
      n = m[1] ? 4 : 2;
      apb(1'b1, TPF_REG_CTRL, {25'h0, m[1], m[1], m[0], m[0], 3'h0});
      w = rnd();
      a_op(1'b0, 1'b1, 1'b1, w);
      tpf_far_model_inst.recv_b(r, n, m[0]);
      `CHK("b_mode", w, r)
      w = rnd();
      tpf_far_model_inst.send_c(w, n, m[0]);
      a_rd();
      `CHK("c_mode", w, r)
    end
    // Passive parity check, then generation on A and B reads
    apb(1'b1, TPF_REG_CTRL, 32'h00000002);
    w = mkpar(rnd(), 1'b0);
    a_op(1'b0, 1'b1, 1'b1, w);
    @(posedge pclk);
    `CHK("perr_ok", 1'b1, a_pe_n)
    a_op(1'b0, 1'b1, 1'b1, w ^ 36'h1);
    @(posedge pclk);
    `CHK("perr_bad", 1'b0, a_pe_n)
    tpf_far_model_inst.recv_b(r, 2, 1'b0);
    tpf_far_model_inst.recv_b(r, 2, 1'b0);
    `CHK("perr_pass", w ^ 36'h1, r)
    apb(1'b1, TPF_REG_CTRL, 32'h00000003);
    w = rnd();
    tpf_far_model_inst.send_c(w, 2, 1'b0);
    a_rd();
    `CHK("pgen_a", mkpar(w, 1'b1), r)
    `CHK("c_perr", (^w[26:18]) && (^w[35:27]), c_pe_n)
    apb(1'b1, TPF_REG_CTRL, 32'h00000005);
    w = rnd();
    a_op(1'b0, 1'b1, 1'b1, w);
    tpf_far_model_inst.recv_b(r, 2, 1'b0);
    `CHK("pgen_b", mkpar(w, 1'b1), r)
    apb(1'b1, TPF_REG_CTRL, 32'h0);
    // Fill A-to-B, refuse one more, drain through B
    for (int i = 0; i < 64; i++)
    begin
      w = rnd();
      qq.push_back(w);
      a_op(1'b0, 1'b1, 1'b1, w);
      repeat (3) @(posedge pclk);
      if (i == 58 || i == 59)
        `CHK("a_af", i == 58, a_af_n)
    end
    `CHK("a_full", 1'b0, a_ff_n)
    a_op(1'b0, 1'b1, 1'b1, 36'hfffffffff);
    for (int i = 63; i >= 0; i--)
    begin
      tpf_far_model_inst.recv_b(r, 2, 1'b0);
      w = qq.pop_front();
      `CHK("ab_data", w, r)
      repeat (4) @(posedge pclk);
      if (i == 5 || i == 4)
        `CHK("b_ae", i == 5, b_ae_n)
    end
    `CHK("a_full_free", 1'b1, a_ff_n)
    `CHK("ab_refused", 1'b0, b_ef_n)
    // Fill C-to-A, drain through A
    for (int i = 0; i < 64; i++)
    begin
      w = rnd();
      qq.push_back(w);
      tpf_far_model_inst.send_c(w, 2, 1'b0);
      repeat (3) @(posedge pclk);
      if (i == 58 || i == 59)
        `CHK("c_af", i == 58, c_af_n)
    end
    `CHK("c_full", 1'b0, c_ff_n)
    for (int i = 63; i >= 0; i--)
    begin
      a_rd();
      w = qq.pop_front();
      `CHK("ca_data", w, r)
      repeat (3) @(posedge pclk);
      if (i == 5 || i == 4)
        `CHK("a_ae", i == 5, a_ae_n)
    end
    `CHK("a_empty_end", 1'b0, a_ef_n)
    // Idle drops at once on a control, device drives A on a read
    repeat (4) @(posedge pclk);
    `CHK("idle", 1'b1, idle)
    a_sel_n <= 1'b0;
    a_gate  <= 1'b1;
    @(posedge pclk);
    `CHK("wake", 1'b0, idle)
    `CHK("a_oe", 1'b0, a_oe_n)
    a_sel_n <= 1'b1;
    a_gate  <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    `CHK("a_oe_off", 1'b1, a_oe_n)
    // Reset mid-run clears queues and takes the new offset
    a_op(1'b0, 1'b1, 1'b1, rnd());
    presetn <= 1'b0;
    osel_lo <= 1'b1;
    osel_hi <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("rst_empty", 1'b0, b_ef_n)
    apb(1'b0, TPF_REG_STAT, 32'h0);
    `CHK("x_sel3", TPF_OFS_3, rd[22:16])
    summarize();
  end
endmodule
